// ### scp_pkg.sv
// Constants shared by both ends of the serial configuration port.
// Assumes a host on a 20 MHz system clock and a device on the link clock.
// Operation
// R01 - Default three-wire port: clock, enable, data
// R02 - Enable low frames access; otherwise ignored
// R03 - Enable high: both data lines undriven
// R04 - Three-wire: output line never driven
// R05 - Four-wire bit: reads leave on output
// R06 - Output line driven only during data
// R07 - Host sends direction, count, address header
// R08 - Data follows header with no gap
// R09 - Option bit 6 selects LSB first
// R10 - MSB first: address decrements per byte
// R11 - LSB first: address increments per byte
// R12 - Header bits sampled on rising edges
// R13 - Write: eight bits per byte, rising
// R14 - Host holds enable low whole transfer
// R15 - Read bytes shifted out on falling edges
// R16 - Four-wire read leaves data line undriven
// R17 - Byte count field value plus one
// R18 - Host writes zero to undefined bits
package scp_pkg;

	// ****************************************
	// Device register map
	// ****************************************
	localparam int SCP_REG_COUNT = 32;
	localparam logic [4:0] SCP_OPT_ADDR = 5'h00;
	localparam int SCP_OPT_FOUR_BIT = 7;
	localparam int SCP_OPT_LSB_BIT = 6;
	localparam logic [7:0] SCP_REG_RESET = 8'h00;

	// ****************************************
	// Instruction header layout
	// ****************************************
	localparam int SCP_HDR_RW_BIT = 7;
	localparam int SCP_HDR_CNT_HI = 6;
	localparam int SCP_HDR_CNT_LO = 5;
	localparam int SCP_HDR_BITS = 8;

	// ****************************************
	// Host register offsets and fields
	// ****************************************
	localparam logic [7:0] SCP_ADDR_CMD = 8'h00;
	localparam logic [7:0] SCP_ADDR_TXD = 8'h04;
	localparam logic [7:0] SCP_ADDR_RXD = 8'h08;
	localparam logic [7:0] SCP_ADDR_STAT = 8'h0C;
	localparam logic [7:0] SCP_ADDR_MODE = 8'h10;
	localparam int SCP_MODE_FOUR_BIT = 0;
	localparam int SCP_MODE_LSB_BIT = 1;
	localparam logic [1:0] SCP_RESP_OKAY = 2'h0;
	localparam logic [1:0] SCP_RESP_SLVERR = 2'h2;

	// ****************************************
	// Timing: link half period in system clocks
	// ****************************************
	localparam int SCP_HALF_PERIOD_CLKS = 4;

	// Reverse the bits of one byte
	function automatic logic [7:0] scp_rev8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	// Shift one serial bit into a byte in the chosen order
	function automatic logic [7:0] scp_shift_in(input logic [7:0] sh, input logic bit_in, input logic lsb);
		return lsb ? {bit_in, sh[7:1]} : {sh[6:0], bit_in};
	endfunction

endpackage

// ### scp_link_if.sv
// Link between host and device of the serial configuration port.
// Assumes each party drives its own enables; the wires resolve here.
`timescale 1ns/1ps
`default_nettype none
interface scp_link_if;
	// Clock and frame, driven by the host
	logic sclk;
	logic port_enable_n;
	// Two-way data line, one driver per party
	logic sdio_host_out;
	logic sdio_host_oe;
	logic sdio_dev_out;
	logic sdio_dev_oe;
	// Separate output line, device only
	logic serial_out_line_dev;
	logic serial_out_line_oe;
	// Resolved levels; an undriven line idles high
	logic sdio_level;
	logic serial_out_line_level;

	assign sdio_level = sdio_host_oe ? sdio_host_out : (sdio_dev_oe ? sdio_dev_out : 1'b1);
	assign serial_out_line_level = serial_out_line_oe ? serial_out_line_dev : 1'b1;

	modport dev (
		input sclk, port_enable_n, sdio_level,
		output sdio_dev_out, sdio_dev_oe, serial_out_line_dev, serial_out_line_oe
	);
	modport host (
		output sclk, port_enable_n, sdio_host_out, sdio_host_oe,
		input sdio_level, serial_out_line_level
	);
endinterface
`default_nettype wire

// ### scp_device.sv
// Device end of the serial configuration port: shifter and registers.
// Assumes the host makes the link clock and frames with the enable.
// Register reset runs on the link clock, so it must toggle during reset.
`timescale 1ns/1ps
`default_nettype none
module scp_device
	import scp_pkg::*;
(
	// Link clock and reset
	input wire logic sclk_link_in,
	input wire logic reset_in,
	// Link to the host
	scp_link_if.dev link,
	// Option bits for the rest of the device
	output logic four_wire_out,
	output logic lsb_first_out
);

	// ****************************************
	// Storage and frame state
	// ****************************************
	logic [7:0] cfg_regs [SCP_REG_COUNT];
	logic [2:0] bit_cnt;
	logic [7:0] shift_reg;
	logic hdr_done;
	logic is_read;
	logic [1:0] bytes_left;
	logic [4:0] cur_addr;
	logic xfer_done;
	logic [7:0] next_shift;
	logic four_wire;
	logic lsb_first;
	logic byte_end;
	logic read_active;
	logic [2:0] out_idx;
	logic out_bit;
	logic sdio_oe;
	logic sol_oe;

	// Option bits come straight from register 0
	assign four_wire = cfg_regs[SCP_OPT_ADDR][SCP_OPT_FOUR_BIT]; // [R05]
	assign lsb_first = cfg_regs[SCP_OPT_ADDR][SCP_OPT_LSB_BIT]; // [R09]
	assign four_wire_out = four_wire;
	assign lsb_first_out = lsb_first;

	// ****************************************
	// Serial input decode
	// ****************************************

	// Assemble the incoming byte in the selected order
	assign next_shift = scp_shift_in(shift_reg, link.sdio_level, lsb_first); // [R09]
	assign byte_end = (bit_cnt == 3'h7);

	// Frame state is cleared by the enable itself, since the clock
	// may stop as soon as the frame ends.
	always_ff @(posedge sclk_link_in or posedge link.port_enable_n) begin
		if (link.port_enable_n) begin // [R02]
			bit_cnt <= 3'h0;
			shift_reg <= 8'h00;
		end else begin
			bit_cnt <= bit_cnt + 3'h1; // [R12] [R13]
			shift_reg <= next_shift;
		end
	end

	// Header capture, then data bytes without a gap
	always_ff @(posedge sclk_link_in or posedge link.port_enable_n) begin
		if (link.port_enable_n) begin
			hdr_done <= 1'b0;
			is_read <= 1'b0;
			bytes_left <= 2'h0;
		end else if (byte_end && !hdr_done) begin
			hdr_done <= 1'b1; // [R08]
			is_read <= next_shift[SCP_HDR_RW_BIT]; // [R07]
			bytes_left <= next_shift[SCP_HDR_CNT_HI:SCP_HDR_CNT_LO]; // [R17]
		end else if (byte_end && !xfer_done && bytes_left != 2'h0) begin
			bytes_left <= bytes_left - 2'h1;
		end
	end

	// Address stepping per finished data byte
	always_ff @(posedge sclk_link_in or posedge link.port_enable_n) begin
		if (link.port_enable_n) begin
			cur_addr <= 5'h00;
		end else if (byte_end && !hdr_done) begin
			cur_addr <= next_shift[4:0];
		end else if (byte_end && !xfer_done) begin
			if (lsb_first) begin
				cur_addr <= cur_addr + 5'h01; // [R11]
			end else begin
				cur_addr <= cur_addr - 5'h01; // [R10]
			end
		end
	end

	// Past the counted bytes, further clocks are ignored
	always_ff @(posedge sclk_link_in or posedge link.port_enable_n) begin
		if (link.port_enable_n) begin
			xfer_done <= 1'b0;
		end else if (byte_end && hdr_done && bytes_left == 2'h0) begin
			xfer_done <= 1'b1; // [R17]
		end
	end

	// ****************************************
	// Register file
	// ****************************************

	// Write a data byte at its last rising edge; reads never disturb
	always_ff @(posedge sclk_link_in) begin
		if (reset_in) begin
			for (int i = 0; i < SCP_REG_COUNT; i++) begin
				cfg_regs[i] <= SCP_REG_RESET; // [R09]
			end
		end else if (!link.port_enable_n && byte_end && hdr_done && !is_read && !xfer_done) begin
			cfg_regs[cur_addr] <= next_shift; // [R13]
		end
	end

	// ****************************************
	// Serial output
	// ****************************************

	// Data phase of a read, before the counted bytes run out
	assign read_active = hdr_done && is_read && !xfer_done;
	assign out_idx = lsb_first ? bit_cnt : (3'h7 - bit_cnt);

	// Drive on falling edges; the bit index follows the rising counter,
	// so the first data bit leaves right after the last header bit.
	always_ff @(negedge sclk_link_in or posedge link.port_enable_n) begin
		if (link.port_enable_n) begin
			out_bit <= 1'b0;
		end else begin
			out_bit <= cfg_regs[cur_addr][out_idx]; // [R15]
		end
	end

	// Output enables; both drop at once when the enable rises
	always_ff @(negedge sclk_link_in or posedge link.port_enable_n) begin
		if (link.port_enable_n) begin
			sdio_oe <= 1'b0; // [R03]
			sol_oe <= 1'b0; // [R03]
		end else begin
			sdio_oe <= read_active && !four_wire; // [R01] [R16]
			sol_oe <= read_active && four_wire; // [R04] [R05] [R06]
		end
	end

	// Same bit on both lines; only the enables pick the live one
	assign link.sdio_dev_out = out_bit;
	assign link.sdio_dev_oe = sdio_oe;
	assign link.serial_out_line_dev = out_bit;
	assign link.serial_out_line_oe = sol_oe;

endmodule // scp_device
`default_nettype wire

// ### scp_host.sv
// Host end: AXI4-Lite register slave driving the serial port as master.
// Assumes software mirrors the device's option bits in the mode register.
`timescale 1ns/1ps
`default_nettype none
module scp_host
	import scp_pkg::*;
#(
	parameter int HALF_PERIOD = SCP_HALF_PERIOD_CLKS
) (
	// System clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Link to the device
	scp_link_if.host link
);

	typedef enum logic [2:0] {
		SCP_S_IDLE = 3'b001,
		SCP_S_RUN = 3'b010,
		SCP_S_END = 3'b100
	} scp_state_t;

	// ****************************************
	// Registers
	// ****************************************
	scp_state_t state;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic aw_got, w_got;
	logic [31:0] tx_data;
	logic [7:0] hdr;
	logic mode_four, mode_lsb;
	logic [31:0] rx_raw;
	logic [39:0] stream;
	logic [5:0] bit_cnt;
	logic [5:0] bit_total;
	logic [7:0] div_cnt;
	logic tick;
	logic sclk, en_n, d_out, d_oe;
	logic sdio_s1, sdio_s2, sol_s1, sol_s2;
	logic do_write, start;
	logic [31:0] rx_view;

	assign link.sclk = sclk;
	assign link.port_enable_n = en_n;
	assign link.sdio_host_out = d_out;
	assign link.sdio_host_oe = d_oe;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign do_write = aw_got && w_got && !s_axi_bvalid_out;
	assign start = do_write && aw_addr == SCP_ADDR_CMD && state == SCP_S_IDLE;

	// Address and data taken in either order, released after response
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end else if (!aw_got && !s_axi_bvalid_out) begin
				s_axi_awready_out <= 1'b1;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata_in;
				s_axi_wready_out <= 1'b0;
			end else if (!w_got && !s_axi_bvalid_out) begin
				s_axi_wready_out <= 1'b1;
			end
			if (do_write) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
			end
		end
	end

	// Write response; a command while busy or a bad offset is refused
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= SCP_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_out <= 1'b1;
			if (aw_addr == SCP_ADDR_TXD || aw_addr == SCP_ADDR_MODE || start) begin
				s_axi_bresp_out <= SCP_RESP_OKAY;
			end else begin
				s_axi_bresp_out <= SCP_RESP_SLVERR;
			end
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// Software-written registers; undefined mode bits stay zero
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			tx_data <= 32'h0;
			mode_four <= 1'b0;
			mode_lsb <= 1'b0;
			hdr <= 8'h00;
		end else if (do_write) begin
			if (aw_addr == SCP_ADDR_TXD && s_axi_wstrb_in != 4'h0) begin
				tx_data <= w_data;
			end
			if (aw_addr == SCP_ADDR_MODE) begin
				mode_four <= w_data[SCP_MODE_FOUR_BIT];
				mode_lsb <= w_data[SCP_MODE_LSB_BIT];
			end
			if (start) begin
				hdr <= w_data[7:0]; // [R07]
			end
		end
	end

	// Received bytes shown in logical bit order
	always_comb begin
		rx_view = rx_raw;
		if (mode_lsb) begin
			for (int i = 0; i < 4; i++) begin
				rx_view[i*8 +: 8] = scp_rev8(rx_raw[i*8 +: 8]);
			end
		end
	end

	// Read channel: one read at a time, unmapped gives an error
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0;
			s_axi_rresp_out <= SCP_RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rresp_out <= SCP_RESP_OKAY;
			unique case (s_axi_araddr_in)
				SCP_ADDR_CMD: s_axi_rdata_out <= {24'h0, hdr};
				SCP_ADDR_TXD: s_axi_rdata_out <= tx_data;
				SCP_ADDR_RXD: s_axi_rdata_out <= rx_view;
				SCP_ADDR_STAT: s_axi_rdata_out <= {31'h0, state != SCP_S_IDLE};
				SCP_ADDR_MODE: s_axi_rdata_out <= {30'h0, mode_lsb, mode_four};
				default: begin
					s_axi_rdata_out <= 32'h0;
					s_axi_rresp_out <= SCP_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end else if (!s_axi_rvalid_out) begin
			s_axi_arready_out <= 1'b1;
		end
	end

	// ****************************************
	// Serial master
	// ****************************************

	// Read data comes back from the link; two flops before use
	always_ff @(posedge clk_sys_in) begin
		sdio_s1 <= link.sdio_level;
		sdio_s2 <= sdio_s1;
		sol_s1 <= link.serial_out_line_level;
		sol_s2 <= sol_s1;
	end

	// Half-period divider; the link clock is a plain register output
	assign tick = (div_cnt == 8'(HALF_PERIOD - 1));
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || state == SCP_S_IDLE || tick) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// Frame sequencer: header then data bytes back to back
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			state <= SCP_S_IDLE;
			sclk <= 1'b0;
			en_n <= 1'b1; // [R02]
			d_out <= 1'b0;
			d_oe <= 1'b0;
			stream <= 40'h0;
			bit_cnt <= 6'h00;
			bit_total <= 6'h00;
			rx_raw <= 32'h0;
		end else begin
			unique case (state)
				SCP_S_IDLE: if (start) begin
					state <= SCP_S_RUN;
					en_n <= 1'b0; // [R14]
					bit_cnt <= 6'h00;
					rx_raw <= 32'h0;
					bit_total <= 6'(SCP_HDR_BITS) + {1'b0, w_data[6:5], 3'h0} + 6'h08; // [R17]
					stream <= mode_lsb ? {scp_rev8(w_data[7:0]), scp_rev8(tx_data[31:24]),
						scp_rev8(tx_data[23:16]), scp_rev8(tx_data[15:8]), scp_rev8(tx_data[7:0])}
						: {w_data[7:0], tx_data}; // [R09]
					d_out <= mode_lsb ? w_data[0] : w_data[7];
					d_oe <= 1'b1;
				end
				SCP_S_RUN: if (tick && !sclk) begin
					sclk <= 1'b1;
					bit_cnt <= bit_cnt + 6'h01;
					if (hdr[SCP_HDR_RW_BIT] && bit_cnt >= 6'(SCP_HDR_BITS)) begin
						rx_raw <= {rx_raw[30:0], mode_four ? sol_s2 : sdio_s2}; // [R15]
					end
				end else if (tick) begin
					sclk <= 1'b0;
					if (bit_cnt == bit_total) begin
						state <= SCP_S_END;
						d_oe <= 1'b0;
					end else begin
						stream <= {stream[38:0], 1'b0};
						d_out <= stream[38]; // [R08] [R13]
						d_oe <= !(hdr[SCP_HDR_RW_BIT] && bit_cnt >= 6'(SCP_HDR_BITS)); // [R16]
					end
				end
				SCP_S_END: if (tick) begin
					state <= SCP_S_IDLE;
					en_n <= 1'b1; // [R14]
				end
				default: state <= SCP_S_IDLE;
			endcase
		end
	end

endmodule // scp_host
`default_nettype wire

// ### scp_link_props.sv
// Checker for the serial link between the host and device ends.
// Assumes it sits beside the link interface, sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module scp_link_props #(
	parameter int HALF_PERIOD = 4
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// Link signals
	input wire logic sclk,
	input wire logic port_enable_n,
	input wire logic sdio_host_out,
	input wire logic sdio_host_oe,
	input wire logic sdio_dev_out,
	input wire logic sdio_dev_oe,
	input wire logic serial_out_line_dev,
	input wire logic serial_out_line_oe,
	input wire logic sdio_level,
	input wire logic serial_out_line_level
);
	// ****************
	// Helper counters
	// ****************
	logic sclk_q;
	logic [7:0] rise_cnt;
	logic [7:0] half_cnt;

	// Rises within a frame; saturates so long frames never wrap
	always_ff @(posedge clk_sys_in) begin
		sclk_q <= sclk;
		if (reset_in || port_enable_n) begin
			rise_cnt <= 8'h00;
		end else if (sclk && !sclk_q && rise_cnt != 8'hFF) begin
			rise_cnt <= rise_cnt + 8'h01;
		end
	end

	// Cycles since the link clock last moved
	always_ff @(posedge clk_sys_in) begin
		half_cnt <= (sclk != sclk_q) ? 8'h00 : half_cnt + 8'h01;
	end

	// ****************
	// Link properties
	// ****************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	chk_idle_released:
	assert property (port_enable_n |-> !sdio_dev_oe && !serial_out_line_oe)
		else $error("device drives a line while idle");
	chk_single_output:
	assert property (!(sdio_dev_oe && serial_out_line_oe))
		else $error("device drives both data lines");
	chk_no_contention:
	assert property (!(sdio_host_oe && sdio_dev_oe))
		else $error("both ends drive the data line");
	chk_host_in_frame:
	assert property (sdio_host_oe |-> !port_enable_n)
		else $error("host drives data outside a frame");
	chk_sclk_idle_low:
	assert property (port_enable_n |-> !sclk)
		else $error("link clock high outside a frame");
	chk_drive_on_fall:
	assert property ($rose(sdio_dev_oe || serial_out_line_oe) |-> $fell(sclk))
		else $error("device output enabled off a falling edge");
	chk_bit_on_fall:
	assert property (((sdio_dev_oe && $changed(sdio_dev_out)) ||
		(serial_out_line_oe && $changed(serial_out_line_dev))) |-> $fell(sclk))
		else $error("read bit changed off a falling edge");
	chk_after_header:
	assert property ((sdio_dev_oe || serial_out_line_oe) |-> rise_cnt >= 8)
		else $error("device drives before the header is done");
	chk_header_driven:
	assert property ((!port_enable_n && rise_cnt < 8) |-> sdio_host_oe)
		else $error("host not driving during the header");
	chk_half_period:
	assert property ($fell(sclk) |-> half_cnt == HALF_PERIOD - 1)
		else $error("link clock half period wrong");
endmodule // scp_link_props
`default_nettype wire

// ### tb_top.sv
// Testbench joining host and device ends, plus a fault bench link.
// Assumes the host is reached over AXI4-Lite and mirrors the option bits.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import scp_pkg::*;
;
	// ****************
	// Clocks and ends
	// ****************
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic boot = 1'b1;
	logic lclk = 1'b0;
	logic dclk1, dclk2, four1, lsb1, four2, lsb2, sol_seen;
	logic [7:0] awaddr, araddr, hdr;
	logic [31:0] wdata, rdata;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int num_errors, tests_run, rises;

	always #25 clk_sys_in = ~clk_sys_in;
	// Bench link clock only runs the device resets
	always #32 lclk = ~lclk;

	scp_link_if link ();
	scp_link_if link2 ();
	assign dclk1 = boot ? lclk : link.sclk;
	assign dclk2 = boot ? lclk : link2.sclk;
	scp_host scp_host_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .link(link));
	scp_device scp_device_inst (.sclk_link_in(dclk1), .reset_in(reset_in), .link(link),
		.four_wire_out(four1), .lsb_first_out(lsb1));
	scp_device scp_device_inst2 (.sclk_link_in(dclk2), .reset_in(reset_in), .link(link2),
		.four_wire_out(four2), .lsb_first_out(lsb2));
	scp_link_props #(.HALF_PERIOD(SCP_HALF_PERIOD_CLKS)) scp_link_props_inst (.clk_sys_in(clk_sys_in),
		.reset_in(reset_in), .sclk(link.sclk), .port_enable_n(link.port_enable_n),
		.sdio_host_out(link.sdio_host_out), .sdio_host_oe(link.sdio_host_oe),
		.sdio_dev_out(link.sdio_dev_out), .sdio_dev_oe(link.sdio_dev_oe),
		.serial_out_line_dev(link.serial_out_line_dev), .serial_out_line_oe(link.serial_out_line_oe),
		.sdio_level(link.sdio_level), .serial_out_line_level(link.serial_out_line_level));

	// Wire monitor: header bits, clock count, output line use
	always @(negedge link.port_enable_n) begin
		rises = 0;
		sol_seen = 1'b0;
	end
	always @(posedge link.sclk) begin
		if (!link.port_enable_n) begin
			if (rises < 8) hdr = {hdr[6:0], link.sdio_level};
			rises++;
		end
	end
	always @(posedge clk_sys_in) begin
		if (link.serial_out_line_oe === 1'b1) sol_seen = 1'b1;
	end

	// ****************
	// Bus and check tasks
	// ****************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Each channel held until its own ready; bready held until bvalid
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clk_sys_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk_sys_in);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clk_sys_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk_sys_in);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	// One link frame: load data, start, poll busy, fetch read bytes
	task automatic xfer(input logic [7:0] cmd, input logic [31:0] txd, output logic [31:0] rx);
		logic [1:0] r;
		logic [31:0] st;
		axi_wr(SCP_ADDR_TXD, txd, r);
		axi_wr(SCP_ADDR_CMD, {24'h000000, cmd}, r);
		check({30'h0, r}, {30'h0, SCP_RESP_OKAY});
		st = 32'h00000001;
		for (int n = 0; n < 500 && st[0] !== 1'b0; n++) axi_rd(SCP_ADDR_STAT, st, r);
		check({31'h0, st[0]}, 32'h0);
		axi_rd(SCP_ADDR_RXD, rx, r);
	endtask

	// Bench-driven frame bits on the fault link, first bit from bits[15]
	task automatic shift2(input logic [15:0] bits, input int n);
		for (int i = 15; i > 15 - n; i--) begin
			link2.sdio_host_out <= bits[i];
			#32 link2.sclk <= 1'b1;
			#32 link2.sclk <= 1'b0;
		end
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic sc_reset();
		logic [31:0] rx;
		check({31'h0, four1}, 32'h0);
		check({31'h0, lsb1}, 32'h0);
		xfer(8'h80, 32'h0, rx);
		check(rx, {24'h0, SCP_REG_RESET});
		check({24'h0, hdr}, 32'h80);
		check(32'(rises), 32'd16);
		check({31'h0, sol_seen}, 32'h0);
	endtask

	task automatic sc_msb_multi();
		logic [31:0] rx;
		xfer(8'h64, 32'hA1B2C3D4, rx);
		check(32'(rises), 32'd40);
		xfer(8'hE4, 32'h0, rx);
		check(rx, 32'hA1B2C3D4);
		check({31'h0, sol_seen}, 32'h0);
		xfer(8'h82, 32'h0, rx);
		check({24'h0, rx[7:0]}, 32'hC3);
		check({24'h0, hdr}, 32'h82);
	endtask

	task automatic sc_lsb();
		logic [31:0] rx;
		logic [1:0] r;
		xfer(8'h00, 32'h40000000, rx);
		check({31'h0, lsb1}, 32'h1);
		axi_wr(SCP_ADDR_MODE, 32'h2, r);
		xfer(8'h25, 32'h5A3C0000, rx);
		check({24'h0, hdr}, 32'hA4);
		xfer(8'h86, 32'h0, rx);
		check({24'h0, rx[7:0]}, 32'h3C);
		xfer(8'hA5, 32'h0, rx);
		check({16'h0, rx[15:0]}, 32'h5A3C);
	endtask

	task automatic sc_four();
		logic [31:0] rx;
		logic [1:0] r;
		xfer(8'h00, 32'h80000000, rx);
		axi_wr(SCP_ADDR_MODE, 32'h1, r);
		check({30'h0, four1, lsb1}, 32'h2);
		xfer(8'hC4, 32'h0, rx);
		check({8'h0, rx[23:0]}, 32'hA1B2C3);
		check({31'h0, sol_seen}, 32'h1);
		xfer(8'h00, 32'h0, rx);
		axi_wr(SCP_ADDR_MODE, 32'h0, r);
		check({31'h0, four1}, 32'h0);
	endtask

	// Unmapped host offsets are refused with zero data
	task automatic sc_refuse();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(8'h1C, 32'h1, r);
		check({30'h0, r}, {30'h0, SCP_RESP_SLVERR});
		axi_rd(8'h1C, d, r);
		check({30'h0, r}, {30'h0, SCP_RESP_SLVERR});
		check(d, 32'h0);
		// A second command while a frame runs must be refused
		axi_wr(SCP_ADDR_CMD, 32'h00000080, r);
		axi_wr(SCP_ADDR_CMD, 32'h00000080, r);
		check({30'h0, r}, {30'h0, SCP_RESP_SLVERR});
		d = 32'h00000001;
		for (int n = 0; n < 500 && d[0] !== 1'b0; n++) axi_rd(SCP_ADDR_STAT, d, r);
		check({31'h0, d[0]}, 32'h0);
	endtask

	// Fault link: bits with enable high, then a frame cut one bit short
	task automatic sc_fault();
		link2.sdio_host_oe <= 1'b1;
		shift2(16'h0080, 16);
		check({31'h0, link2.sdio_dev_oe}, 32'h0);
		check({31'h0, four2}, 32'h0);
		link2.port_enable_n <= 1'b0;
		shift2(16'h0080, 15);
		#32 link2.port_enable_n <= 1'b1;
		#64 check({31'h0, four2}, 32'h0);
		link2.port_enable_n <= 1'b0;
		shift2(16'h0080, 16);
		#32 link2.port_enable_n <= 1'b1;
		link2.sdio_host_oe <= 1'b0;
		#64 check({31'h0, four2}, 32'h1);
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		link2.sclk = 1'b0;
		link2.port_enable_n = 1'b1;
		link2.sdio_host_out = 1'b1;
		link2.sdio_host_oe = 1'b0;
		num_errors = 0;
		tests_run = 0;
		repeat (4) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		@(posedge clk_sys_in);
		boot <= 1'b0;
		sc_reset();
		sc_msb_multi();
		sc_lsb();
		sc_four();
		sc_refuse();
		sc_fault();
		wrap_up();
	end

	// Watchdog: a few times the expected run length
	initial begin
		#1000000;
		num_errors++;
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
